// [ipm_defines.svh]
// constants for the idle power manager
`ifndef IPM_DEFINES_SVH
`define IPM_DEFINES_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define IPM_CTRL_OFS 8'h00
`define IPM_TMO_OFS 8'h04
`define IPM_EVEN_OFS 8'h08
`define IPM_STAT_OFS 8'h0C
// ---------------------------------------------------------------
// control field positions
// ---------------------------------------------------------------
`define IPM_PROF_LSB 0
`define IPM_VMETH_LSB 2
`define IPM_VSUSP_BIT 4
`define IPM_HALT_BIT 5
`define IPM_BTN_BIT 6
`define IPM_PCIW_BIT 7
`define IPM_RING_BIT 8
`define IPM_ALRM_BIT 9
`define IPM_MDM_LSB 12
// timeout register fields: suspend code [3:0], disk code [7:4]
`define IPM_SUSP_LSB 0
`define IPM_DISK_LSB 4
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define IPM_CTRL_RST 32'h0000_3000
`define IPM_TMO_RST 32'h0000_0000
`define IPM_EVEN_RST 32'h0000_0000
// ---------------------------------------------------------------
// timing, in minutes and seconds
// ---------------------------------------------------------------
`define IPM_CLK_HZ 20000000
`define IPM_SEC_CYC (`IPM_CLK_HZ)
`define IPM_OFF_DELAY_S 4
`define IPM_MIN_S 60
`define IPM_HOUR_MIN 60
`define IPM_BAD_RESP 2'b10
`endif

// [ipm_pkg.sv]
// types for the idle power manager
package ipm_pkg;
  typedef enum logic [1:0] {IPM_PROF_OFF, IPM_PROF_MIN, IPM_PROF_USER,
    IPM_PROF_MAX} ipm_prof_t;
  typedef enum logic [1:0] {IPM_VID_SYNCBLANK, IPM_VID_DPMS,
    IPM_VID_BLANK, IPM_VID_RSV} ipm_vid_t;
  typedef enum {IPM_ST_RUN, IPM_ST_SUSP, IPM_ST_OFFWAIT,
    IPM_ST_OFF} ipm_state_t;
endpackage

// [ipm_idle_power_manager.sv]
// idle power manager: activity timers, suspend, wake and power button
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "ipm_defines.svh"
module ipm_idle_power_manager
  import ipm_pkg::*;
#(
  parameter int SEC_CYC = `IPM_SEC_CYC,
  parameter int NUM_IRQ = 16
)(
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] disk_act_i,
  input wire logic legacy_act_i,
  input wire logic [3:0] pci_interrupt_lines_i,
  input wire logic [NUM_IRQ-1:0] irq_i,
  input wire logic pci_wake_i,
  input wire logic ring_i,
  input wire logic alarm_i,
  input wire logic power_button_i,
  output logic dev_pwr_o,
  output logic disk_idle_shutdown_o,
  output logic video_pwr_o,
  output logic hsync_en_o,
  output logic vsync_en_o,
  output logic blank_o,
  output logic cpu_idle_o,
  output logic supply_on_o
);
  // ---------------------------------------------------------------
  // registers and bus slave
  // ---------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] tmo;
  logic [31:0] even;
  logic [7:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  ipm_state_t state;
  logic wr_go;
  logic [31:0] next_rdata;
  logic next_rok;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_full && w_full && !s_axi_bvalid;

  // address and data may arrive in either order
  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_full <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
        w_full <= 1'b0;
    end

  // byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == `IPM_CTRL_OFS || a == `IPM_TMO_OFS ||
      a == `IPM_EVEN_OFS || a == `IPM_STAT_OFS;
  endfunction

  // register writes and the write response
  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      ctrl <= `IPM_CTRL_RST;
      tmo <= `IPM_TMO_RST;
      even <= `IPM_EVEN_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? 2'b00 : `IPM_BAD_RESP;
        case (aw_addr)
          `IPM_CTRL_OFS: ctrl <= merge(ctrl, w_data, w_strb);
          `IPM_TMO_OFS: tmo <= merge(tmo, w_data, w_strb);
          `IPM_EVEN_OFS: even <= merge(even, w_data, w_strb);
          default: ;
        endcase
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  ipm_prof_t prof;
  ipm_vid_t vmeth;
  logic [3:0] mdm_irq;
  assign prof = ipm_prof_t'(ctrl[`IPM_PROF_LSB +: 2]);
  assign vmeth = ipm_vid_t'(ctrl[`IPM_VMETH_LSB +: 2]);
  assign mdm_irq = ctrl[`IPM_MDM_LSB +: 4];

  // timer code to minutes: 0 off, 1..9 = 1/2/4/6/8/10/20/30/40, else 60
  function automatic logic [6:0] code_min(input logic [3:0] c);
    case (c)
      4'h0: return 7'd0;
      4'h1: return 7'd1;
      4'h2: return 7'd2;
      4'h3: return 7'd4;
      4'h4: return 7'd6;
      4'h5: return 7'd8;
      4'h6: return 7'd10;
      4'h7: return 7'd20;
      4'h8: return 7'd30;
      4'h9: return 7'd40;
      default: return 7'(`IPM_HOUR_MIN);
    endcase
  endfunction

  // suspend minutes; 0 means never suspend
  logic [6:0] susp_min;
  logic [6:0] disk_min;
  always_comb
  begin
    case (prof)
      IPM_PROF_MAX: susp_min = 7'd1;
      IPM_PROF_MIN: susp_min = 7'(`IPM_HOUR_MIN);
      IPM_PROF_USER: susp_min = code_min(tmo[`IPM_SUSP_LSB +: 4]);
      default: susp_min = 7'd0;
    endcase
    // min profile leaves the disk on its own setting
    case (prof)
      IPM_PROF_MAX: disk_min = 7'd1;
      IPM_PROF_OFF: disk_min = 7'd0;
      default: disk_min = code_min(tmo[`IPM_DISK_LSB +: 4]);
    endcase
  end

  // ---------------------------------------------------------------
  // activity and wake sources
  // ---------------------------------------------------------------
  logic activity;
  logic disk_any;
  logic wake;
  logic modem_ring;
  assign disk_any = |(disk_act_i & even[3:0]);
  assign activity = disk_any || (legacy_act_i && even[4]) ||
    ((|pci_interrupt_lines_i) && even[5]);
  assign modem_ring = irq_i[mdm_irq];
  assign wake = activity || modem_ring ||
    (pci_wake_i && ctrl[`IPM_PCIW_BIT]) ||
    (ring_i && ctrl[`IPM_RING_BIT]) ||
    (alarm_i && ctrl[`IPM_ALRM_BIT]);

  // ---------------------------------------------------------------
  // second tick and idle timers
  // ---------------------------------------------------------------
  logic [31:0] pre;
  logic tick;
  logic [11:0] susp_sec;
  logic [11:0] disk_sec;
  logic susp_due;
  logic disk_off;
  assign tick = pre == 32'(SEC_CYC - 1);

  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
      pre <= 32'h0000_0000;
    else
      pre <= tick ? 32'h0000_0000 : pre + 32'h0000_0001;

  // idle seconds counted up; reloading means clearing
  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      susp_sec <= 12'h000;
      disk_sec <= 12'h000;
      disk_off <= 1'b0;
    end
    else
    begin
      if (activity || state != IPM_ST_RUN || susp_min == 7'd0)
        susp_sec <= 12'h000;
      else if (tick && !susp_due)
        susp_sec <= susp_sec + 12'h001;
      // a disabled code, disk activity or leaving run restarts the count, so a stale count
      // cannot fire at once or run past the limit and wrap
      if (disk_any || state != IPM_ST_RUN || disk_min == 7'd0)
      begin
        disk_sec <= 12'h000;
        disk_off <= 1'b0;
      end
      else if (disk_sec >= 12'(disk_min * `IPM_MIN_S))
        disk_off <= 1'b1;
      else if (tick)
        disk_sec <= disk_sec + 12'h001;
    end
  assign susp_due = susp_min != 7'd0 &&
    susp_sec >= 12'(susp_min * `IPM_MIN_S);

  // ---------------------------------------------------------------
  // power state machine
  // ---------------------------------------------------------------
  logic [31:0] off_cnt;
  logic btn_q;
  logic btn_press;
  assign btn_press = power_button_i && !btn_q;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
      btn_q <= 1'b0;
    else
      btn_q <= power_button_i;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      state <= IPM_ST_RUN;
      off_cnt <= 32'h0000_0000;
    end
    else
      case (state)
        IPM_ST_RUN:
          if (btn_press)
          begin
            off_cnt <= 32'h0000_0000;
            state <= ctrl[`IPM_BTN_BIT] ? IPM_ST_OFFWAIT
              : IPM_ST_OFF;
          end
          else if (susp_due && !activity)
            state <= IPM_ST_SUSP;
        IPM_ST_SUSP:
          if (btn_press)
            state <= ctrl[`IPM_BTN_BIT] ? IPM_ST_OFFWAIT : IPM_ST_OFF;
          else if (wake)
            state <= IPM_ST_RUN;
        IPM_ST_OFFWAIT:
          if (btn_press) // restart at once inside the window
            state <= IPM_ST_RUN;
          else if (tick && off_cnt == 32'(`IPM_OFF_DELAY_S - 1))
            state <= IPM_ST_OFF;
          else if (tick)
            off_cnt <= off_cnt + 32'h0000_0001;
        IPM_ST_OFF:
          if (btn_press || (ring_i && ctrl[`IPM_RING_BIT]))
            state <= IPM_ST_RUN;
        default: state <= IPM_ST_RUN;
      endcase

  // ---------------------------------------------------------------
  // power and video outputs
  // ---------------------------------------------------------------
  logic saving;
  assign saving = state == IPM_ST_SUSP || state == IPM_ST_OFFWAIT;

  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      dev_pwr_o <= 1'b1;
      disk_idle_shutdown_o <= 1'b0;
      video_pwr_o <= 1'b1;
      hsync_en_o <= 1'b1;
      vsync_en_o <= 1'b1;
      blank_o <= 1'b0;
      cpu_idle_o <= 1'b0;
      supply_on_o <= 1'b1;
    end
    else
    begin
      dev_pwr_o <= state == IPM_ST_RUN;
      disk_idle_shutdown_o <= disk_off || state != IPM_ST_RUN;
      video_pwr_o <= !(saving && ctrl[`IPM_VSUSP_BIT]) &&
        state != IPM_ST_OFF;
      // dpms leaves syncs to the display driver
      hsync_en_o <= !(saving && vmeth == IPM_VID_SYNCBLANK);
      vsync_en_o <= !(saving && vmeth == IPM_VID_SYNCBLANK);
      blank_o <= saving && (vmeth == IPM_VID_SYNCBLANK ||
        vmeth == IPM_VID_BLANK);
      cpu_idle_o <= saving && ctrl[`IPM_HALT_BIT];
      supply_on_o <= state != IPM_ST_OFF;
    end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rok = mapped(s_axi_araddr);
    case (s_axi_araddr)
      `IPM_CTRL_OFS: next_rdata = ctrl;
      `IPM_TMO_OFS: next_rdata = tmo;
      `IPM_EVEN_OFS: next_rdata = even;
      `IPM_STAT_OFS: next_rdata = {20'h00000, susp_sec};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i)
    if (sys_rst_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rok ? 2'b00 : `IPM_BAD_RESP;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_never_susp: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    susp_min == 7'd0 && state == IPM_ST_RUN |=> state != IPM_ST_SUSP)
    else $error("suspend entered while disabled");
  a_reload_timer: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    activity |=> susp_sec == 12'h000)
    else $error("suspend timer not reloaded");
  a_susp_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state == IPM_ST_SUSP |=> !dev_pwr_o && disk_idle_shutdown_o)
    else $error("devices on in suspend");
  a_instant_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state == IPM_ST_RUN && btn_press && !ctrl[`IPM_BTN_BIT]
    |=> ##1 !supply_on_o)
    else $error("instant off late");
  a_delay_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state == IPM_ST_RUN && btn_press && ctrl[`IPM_BTN_BIT]
    |=> ##1 supply_on_o && !dev_pwr_o)
    else $error("delayed off not suspended");
  a_sync_blank: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    saving && vmeth == IPM_VID_SYNCBLANK |=> !hsync_en_o && blank_o)
    else $error("sync blank method wrong");
  a_blank_only: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    saving && vmeth == IPM_VID_BLANK |=> hsync_en_o && blank_o)
    else $error("blank only method wrong");
  a_wake_resume: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state == IPM_ST_SUSP && wake && !btn_press |=> ##1 dev_pwr_o)
    else $error("wake did not resume");
  a_cpu_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    state == IPM_ST_SUSP && ctrl[`IPM_HALT_BIT] |=> cpu_idle_o)
    else $error("processor not idle");
  c_suspend: cover property (@(posedge mclk_i) state == IPM_ST_SUSP);
  c_resume: cover property (@(posedge mclk_i)
    state == IPM_ST_SUSP ##1 state == IPM_ST_RUN);
  c_offwait: cover property (@(posedge mclk_i) state == IPM_ST_OFFWAIT);
  c_disk_down: cover property (@(posedge mclk_i) disk_off);
endmodule

// [ipm_partner.sv]
// activity, wake and button source model for the idle power manager
module ipm_partner
(
  input wire logic mclk_i,
  output logic [3:0] disk_act_o,
  output logic legacy_act_o,
  output logic [3:0] pci_lines_o,
  output logic [15:0] irq_o,
  output logic pci_wake_o,
  output logic ring_o,
  output logic alarm_o,
  output logic power_button_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // one bit per source, quiet until a burst is asked for
  logic [28:0] src;
  initial src = 29'h0;
  // source map: disks, legacy, pci lines, irqs, wake, ring, alarm, button
  assign disk_act_o = src[3:0];
  assign legacy_act_o = src[4];
  assign pci_lines_o = src[8:5];
  assign irq_o = src[24:9];
  assign pci_wake_o = src[25];
  assign ring_o = src[26];
  assign alarm_o = src[27];
  assign power_button_o = src[28];
  // two clocks wide so the button also gives a clean rising edge
  task automatic pulse_src(input int idx);
    @(posedge mclk_i);
    src[idx] <= 1'b1;
    repeat (2) @(posedge mclk_i);
    src[idx] <= 1'b0;
  endtask
endmodule

// [test_idle_power_manager.sv]
// self-checking bench for the idle power manager
`include "ipm_defines.svh"
module test_idle_power_manager;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------
  // signals
  // ------------------------------------------------
  // short second keeps one hour at 14400 clocks
  localparam int SC = 4;
  localparam int T = 60 * SC;
  localparam int DEV = 0, DISK = 1, VPWR = 2, HS = 3, VS = 4;
  localparam int BLK = 5, CPU = 6, SUP = 7;
  logic mclk_i;
  logic sys_rst_i;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [3:0] disk_act, pci_lines;
  logic [15:0] irq;
  logic legacy_act, pci_wake, ring, alarm, power_button;
  wire logic [7:0] outs;
  int n_errors = 0;
  int check_count = 0;
  always #25 mclk_i = ~mclk_i;
  ipm_partner ipm_partner_inst (.mclk_i(mclk_i), .disk_act_o(disk_act),
    .legacy_act_o(legacy_act), .pci_lines_o(pci_lines), .irq_o(irq),
    .pci_wake_o(pci_wake), .ring_o(ring), .alarm_o(alarm),
    .power_button_o(power_button));
  ipm_idle_power_manager #(.SEC_CYC(SC), .NUM_IRQ(16))
    ipm_idle_power_manager_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .disk_act_i(disk_act),
    .legacy_act_i(legacy_act), .pci_interrupt_lines_i(pci_lines),
    .irq_i(irq), .pci_wake_i(pci_wake), .ring_i(ring), .alarm_i(alarm),
    .power_button_i(power_button), .dev_pwr_o(outs[DEV]),
    .disk_idle_shutdown_o(outs[DISK]), .video_pwr_o(outs[VPWR]),
    .hsync_en_o(outs[HS]), .vsync_en_o(outs[VS]), .blank_o(outs[BLK]),
    .cpu_idle_o(outs[CPU]), .supply_on_o(outs[SUP]));
  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic stop_test();
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_bit(input string what, input logic got,
    input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_word(input string what, input logic [31:0] got,
    input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // output must keep its level for n clocks
  task automatic hold_out(input int idx, input logic val, input int n);
    logic ok;
    ok = 1'b1;
    repeat (n)
    begin
      @(posedge mclk_i);
      if (outs[idx] !== val) ok = 1'b0;
    end
    chk_bit("hold", ok, 1'b1);
  endtask
  // bounded wait; a miss ends the run rather than hanging
  task automatic wait_out(input int idx, input logic val, input int lim);
    int i;
    i = 0;
    while (outs[idx] !== val && i < lim)
    begin
      @(posedge mclk_i);
      i++;
    end
    chk_bit("wait", outs[idx], val);
    if (outs[idx] !== val) stop_test();
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] resp);
    int i;
    @(posedge mclk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk_i);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    chk_word("bresp", {30'h0, s_axi_bresp}, {30'h0, resp});
    if (i == 50)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] resp);
    int i;
    @(posedge mclk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge mclk_i);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    chk_word("rdata", s_axi_rdata, d);
    chk_word("rresp", {30'h0, s_axi_rresp}, {30'h0, resp});
    if (i == 50)
    begin
      n_errors++;
      stop_test();
    end
  endtask
  // legacy activity after setup so every suspend idle period starts here
  task automatic cfg(input logic [31:0] c, input logic [31:0] t,
    input logic [31:0] e);
    axi_wr(`IPM_CTRL_OFS, c, 2'b00);
    axi_wr(`IPM_TMO_OFS, t, 2'b00);
    axi_wr(`IPM_EVEN_OFS, e, 2'b00);
    ipm_partner_inst.pulse_src(4);
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    // bus idle and reset asserted from time zero
    mclk_i = 1'b0;
    sys_rst_i <= 1'b1;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (6) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    chk_word("rst outs", {24'h0, outs}, 32'h0000_009D);
    axi_rd(`IPM_CTRL_OFS, `IPM_CTRL_RST, 2'b00);
    axi_rd(`IPM_TMO_OFS, `IPM_TMO_RST, 2'b00);
    axi_rd(`IPM_EVEN_OFS, `IPM_EVEN_RST, 2'b00);
    axi_rd(8'h10, 32'h0, `IPM_BAD_RESP);
    axi_wr(8'h20, 32'hFFFF_FFFF, `IPM_BAD_RESP);
    // only the low byte lane is strobed
    s_axi_wstrb <= 4'h1;
    axi_wr(`IPM_TMO_OFS, 32'hFFFF_FF05, 2'b00);
    s_axi_wstrb <= 4'hF;
    axi_rd(`IPM_TMO_OFS, 32'h0000_0005, 2'b00);
    // suspend code zero: no suspend however long the idle
    cfg(32'h0000_3002, 32'h0, 32'h10);
    hold_out(DEV, 1'b1, 2 * T);
    chk_bit("disk", outs[DISK], 1'b0);
    // max saving, sync off and blank, video off, halt type
    cfg(32'h0000_3033, 32'h0, 32'h10);
    axi_rd(`IPM_CTRL_OFS, 32'h0000_3033, 2'b00);
    hold_out(DEV, 1'b1, T - 2 * SC - 12);
    wait_out(DEV, 1'b0, 4 * SC + 8);
    repeat (2) @(posedge mclk_i);
    chk_bit("cpu", outs[CPU], 1'b1);
    chk_bit("vpwr", outs[VPWR], 1'b0);
    chk_bit("hs", outs[HS], 1'b0);
    chk_bit("vs", outs[VS], 1'b0);
    chk_bit("blank", outs[BLK], 1'b1);
    chk_bit("supply", outs[SUP], 1'b1);
    ipm_partner_inst.pulse_src(12);
    wait_out(DEV, 1'b1, 8);
    // user profile, blank only, disk activity halfway through
    cfg(32'h0000_308A, 32'h1, 32'h11);
    hold_out(DEV, 1'b1, T / 2);
    ipm_partner_inst.pulse_src(0);
    hold_out(DEV, 1'b1, T - 2 * SC);
    wait_out(DEV, 1'b0, 4 * SC + 8);
    repeat (2) @(posedge mclk_i);
    chk_bit("hs", outs[HS], 1'b1);
    chk_bit("vs", outs[VS], 1'b1);
    chk_bit("blank", outs[BLK], 1'b1);
    chk_bit("vpwr", outs[VPWR], 1'b1);
    ipm_partner_inst.pulse_src(25);
    wait_out(DEV, 1'b1, 8);
    // disk down at 1 min, pci lines reload the 2 min suspend
    cfg(32'h0000_3202, 32'h12, 32'h30);
    hold_out(DISK, 1'b0, T - 2 * SC - 12);
    wait_out(DISK, 1'b1, 4 * SC + 8);
    chk_bit("dev", outs[DEV], 1'b1);
    ipm_partner_inst.pulse_src(5);
    hold_out(DEV, 1'b1, 2 * T - 2 * SC);
    wait_out(DEV, 1'b0, 4 * SC + 8);
    ipm_partner_inst.pulse_src(27);
    wait_out(DEV, 1'b1, 8);
    repeat (2) @(posedge mclk_i);
    chk_bit("disk", outs[DISK], 1'b0);
    hold_out(DEV, 1'b1, 2 * T - 3 * SC);
    // min saving: disk uses its code, suspend only after one hour
    // disk timer restarts from its own enabled activity
    cfg(32'h0000_3001, 32'h10, 32'h11);
    ipm_partner_inst.pulse_src(0);
    hold_out(DISK, 1'b0, T - 2 * SC - 12);
    wait_out(DISK, 1'b1, 4 * SC + 8);
    hold_out(DEV, 1'b1, 59 * T - 4 * SC - 8);
    wait_out(DEV, 1'b0, 8 * SC + 16);
    ipm_partner_inst.pulse_src(12);
    wait_out(DEV, 1'b1, 8);
    // instant off, then ring powers the system up
    cfg(32'h0000_3100, 32'h0, 32'h10);
    ipm_partner_inst.pulse_src(28);
    wait_out(SUP, 1'b0, 8);
    ipm_partner_inst.pulse_src(26);
    wait_out(SUP, 1'b1, 8);
    repeat (2) @(posedge mclk_i);
    chk_bit("dev", outs[DEV], 1'b1);
    // delayed off: suspend window of about four seconds
    cfg(32'h0000_3040, 32'h0, 32'h10);
    ipm_partner_inst.pulse_src(28);
    wait_out(DEV, 1'b0, 8);
    hold_out(SUP, 1'b1, 3 * SC - 4);
    wait_out(SUP, 1'b0, 2 * SC + 8);
    ipm_partner_inst.pulse_src(28);
    wait_out(SUP, 1'b1, 8);
    stop_test();
  end
endmodule
